/* hw/smcg_pkg.sv */
package smcg_pkg;
    // Bus and register map
    localparam int          ADR_W        = 12;
    localparam logic [11:0] OFS_SCG0     = 12'h0110;
    localparam logic [11:0] OFS_CTRL     = 12'h0114;
    localparam logic [11:0] OFS_STAT     = 12'h0118;
    // Sleep gating register layout
    localparam logic [31:0] SCG0_RESET   = 32'h0000_0040;
    localparam logic [31:0] SCG0_WMASK   = 32'h0011_0348;
    localparam int          BIT_PWM      = 20;
    localparam int          BIT_CONV     = 16;
    localparam int          BIT_HIBER    = 6;
    localparam int          BIT_WDOG     = 3;
    localparam int          RATE_LSB     = 8;
    localparam int          RATE_MSB     = 9;
    localparam logic [1:0]  RATE_500K    = 2'h2;
    localparam logic [1:0]  RATE_250K    = 2'h1;
    localparam logic [1:0]  RATE_125K    = 2'h0;
    // Control and status layout
    localparam int          BIT_AUTO_GATE = 0;
    localparam logic        AUTO_GATE_RST = 1'b0;
    localparam int          BIT_INSLEEP  = 8;
    // Peripheral indices
    localparam int          NUM_PER      = 4;
    localparam int          PER_PWM      = 0;
    localparam int          PER_CONV     = 1;
    localparam int          PER_HIBER    = 2;
    localparam int          PER_WDOG     = 3;
    localparam logic [3:0]  EN_RESET     = 4'h4;
    // Clock-enable boundary timing
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          GATE_PERIOD_NS = 40;
    localparam int          GATE_DIV       = GATE_PERIOD_NS / CLK_PERIOD_NS;
endpackage

/* hw/smcg_gate_cell.sv */
`timescale 1ns/10ps
module smcg_gate_cell #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic tick_i,
    input  wire logic req_i,
    output logic      en_o
);
    typedef struct packed {
        logic en;
    } smcg_cell_type;

    smcg_cell_type st_ff;
    smcg_cell_type nxt_st;

    // Enable moves only on a boundary tick
    always_comb begin
        nxt_st = st_ff;
        if (tick_i) begin
            nxt_st.en = req_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff.en <= RST_VAL;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign en_o = st_ff.en;

    AST_CELL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !tick_i |=> en_o == $past(en_o))
        else $error("Gate enable moved off a boundary");
endmodule

/* hw/smcg_top.sv */
// Overview of operation
// - In sleep with auto gate select set, a set gating bit clocks its peripheral; a clear bit leaves it unclocked.
// - Access to a peripheral whose clock is off answers with a bus fault.
// - Gating register lives at 0x110 and resets to 0x00000040.
// - Sleep bits steer clocks only in sleep with auto gate select set.
// - Bit 20 gates the PWM clock, read/write, reset zero.
// - Bit 16 gates converter 0 clock, read/write, reset zero.
// - Bit 3 gates the watchdog clock, read/write, reset zero.
// - Bit 6 gates the hibernation clock, read/write, reset one.
// - Bits 9:8 pick converter rate: 2=500K, 1=250K, 0=125K; reset zero.
// - Reserved bits are read-only and read as zero.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/10ps
module smcg_top
    import smcg_pkg::*;
#(
    parameter int DIV = GATE_DIV
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADR_W-1:0]  adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    input  wire logic              sleep_i,
    input  wire logic [NUM_PER-1:0] run_gate_i,
    input  wire logic              acc_req_i,
    input  wire logic [1:0]        acc_sel_i,
    output logic                   acc_ok_o,
    output logic                   acc_fault_o,
    output logic [NUM_PER-1:0]     periph_clk_en_o,
    output logic [1:0]             rate_sel_o
);
    localparam int DIV_W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);

    typedef struct packed {
        logic [31:0]      scg0;
        logic             auto_gate;
        logic             ack;
        logic [31:0]      dat;
        logic [DIV_W-1:0] div;
        logic             tick;
        logic             ok;
        logic             fault;
        logic [1:0]       rate;
    } smcg_state_type;

    smcg_state_type    st_ff;
    smcg_state_type    nxt_st;
    logic [NUM_PER-1:0] en_w;
    logic [NUM_PER-1:0] sleep_req;
    logic [NUM_PER-1:0] req_w;
    logic              use_sleep;
    logic              bus_req;
    logic              wr_scg;
    logic              wr_ctrl;
    logic [31:0]       bmask;
    logic [31:0]       scg_new;
    logic [31:0]       rd_val;

    // Byte lane mask from sel
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bmask[8*i +: 8] = {8{sel_i[i]}};
        end
    end

    assign bus_req = cyc_i && stb_i && !st_ff.ack;
    assign wr_scg  = bus_req && we_i && (adr_i == OFS_SCG0);
    assign wr_ctrl = bus_req && we_i && (adr_i == OFS_CTRL) && sel_i[0];

    // Only writable positions take data; reserved stay zero
    assign scg_new = (st_ff.scg0 & ~(bmask & SCG0_WMASK))
                   | (dat_i & bmask & SCG0_WMASK);

    // Sleep bits in peripheral order
    assign sleep_req[PER_PWM]  = st_ff.scg0[BIT_PWM];
    assign sleep_req[PER_CONV] = st_ff.scg0[BIT_CONV];
    assign sleep_req[PER_HIBER] = st_ff.scg0[BIT_HIBER];
    assign sleep_req[PER_WDOG]  = st_ff.scg0[BIT_WDOG];

    assign use_sleep = sleep_i && st_ff.auto_gate;
    assign req_w     = use_sleep ? sleep_req : run_gate_i;

    // Read mux
    always_comb begin
        rd_val = 32'h0000_0000;
        if (adr_i == OFS_SCG0) begin
            rd_val = st_ff.scg0 & SCG0_WMASK;
        end else if (adr_i == OFS_CTRL) begin
            rd_val[BIT_AUTO_GATE] = st_ff.auto_gate;
        end else if (adr_i == OFS_STAT) begin
            rd_val[NUM_PER-1:0] = en_w;
            rd_val[BIT_INSLEEP] = use_sleep;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        // Boundary divider
        nxt_st.tick = 1'b0;
        if (st_ff.div == DIV_LAST) begin
            nxt_st.div  = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.div = st_ff.div + DIV_W'(1);
        end
        // Wishbone slave, registered ack one cycle after the request
        nxt_st.ack = bus_req;
        if (bus_req) begin
            nxt_st.dat = we_i ? 32'h0000_0000 : rd_val;
        end
        if (wr_scg) begin
            nxt_st.scg0 = scg_new;
        end
        if (wr_ctrl) begin
            nxt_st.auto_gate = dat_i[BIT_AUTO_GATE];
        end
        nxt_st.rate = nxt_st.scg0[RATE_MSB:RATE_LSB];
        // Peripheral access check
        nxt_st.ok    = acc_req_i && en_w[acc_sel_i];
        nxt_st.fault = acc_req_i && !en_w[acc_sel_i];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff.scg0  <= SCG0_RESET;
            st_ff.auto_gate <= AUTO_GATE_RST;
            st_ff.ack   <= 1'b0;
            st_ff.dat   <= 32'h0000_0000;
            st_ff.div   <= '0;
            st_ff.tick  <= 1'b0;
            st_ff.ok    <= 1'b0;
            st_ff.fault <= 1'b0;
            st_ff.rate  <= SCG0_RESET[RATE_MSB:RATE_LSB];
        end else begin
            st_ff <= nxt_st;
        end
    end

    // One clean enable per peripheral
    for (genvar g = 0; g < NUM_PER; g++) begin : g_cell
        smcg_gate_cell #(
            .RST_VAL (EN_RESET[g])
        ) u_cell (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .tick_i  (st_ff.tick),
            .req_i   (req_w[g]),
            .en_o    (en_w[g])
        );
    end

    assign dat_o           = st_ff.dat;
    assign ack_o           = st_ff.ack;
    assign acc_ok_o        = st_ff.ok;
    assign acc_fault_o     = st_ff.fault;
    assign periph_clk_en_o = en_w;
    assign rate_sel_o      = st_ff.rate;

    // Assertions
    sequence seq_tick_sleep;
        st_ff.tick && use_sleep;
    endsequence

    sequence seq_tick_run;
        st_ff.tick && !use_sleep;
    endsequence

    sequence seq_scg_write;
        wr_scg && (sel_i == 4'hF);
    endsequence

    sequence seq_ctrl_write;
        wr_ctrl;
    endsequence

    sequence seq_rd_scg;
        bus_req && !we_i && (adr_i == OFS_SCG0);
    endsequence

    sequence seq_rd_ctrl;
        bus_req && !we_i && (adr_i == OFS_CTRL);
    endsequence

    sequence seq_rd_stat;
        bus_req && !we_i && (adr_i == OFS_STAT);
    endsequence

    sequence seq_bus_write;
        bus_req && we_i;
    endsequence

    sequence seq_bus_idle;
        !(cyc_i && stb_i);
    endsequence

    AST_RESET_VAL: assert property (@(posedge clk_i)
        $past(rst_i) && !rst_i |-> st_ff.scg0 == SCG0_RESET && en_w == EN_RESET)
        else $error("Gating register reset value wrong");

    AST_SLEEP_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_tick_sleep |=> en_w == $past(sleep_req))
        else $error("Sleep enables not applied in sleep");

    AST_RUN_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_tick_run |=> en_w == $past(run_gate_i))
        else $error("Run enables not applied outside sleep");

    AST_WRITE_BITS: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_scg_write |=> st_ff.scg0 == ($past(dat_i) & SCG0_WMASK))
        else $error("Gating write did not store masked data");

    AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && (adr_i == OFS_SCG0) |-> (st_ff.scg0 & ~SCG0_WMASK) == 32'h0000_0000
        && (dat_o & ~SCG0_WMASK) == 32'h0000_0000)
        else $error("Reserved bit reads nonzero");

    AST_FAULT: assert property (@(posedge clk_i) disable iff (rst_i)
        acc_req_i && !en_w[acc_sel_i] |=> acc_fault_o && !acc_ok_o)
        else $error("Gated access did not fault");

    AST_OK: assert property (@(posedge clk_i) disable iff (rst_i)
        acc_req_i && en_w[acc_sel_i] |=> acc_ok_o && !acc_fault_o)
        else $error("Clocked access faulted");

    AST_EDGE_ON_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
        en_w != $past(en_w) |-> $past(st_ff.tick))
        else $error("Enable changed between boundaries");

    AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("Bus ack not one cycle after request");

    AST_RATE: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_scg_write |=> rate_sel_o == $past(dat_i[RATE_MSB:RATE_LSB]))
        else $error("Rate output does not follow field");

    AST_RD_SCG: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_rd_scg |=> dat_o == ($past(st_ff.scg0) & SCG0_WMASK))
        else $error("Gating register read data wrong");

    AST_RD_CTRL: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_rd_ctrl |=> dat_o == {31'h0000_0000, $past(st_ff.auto_gate)})
        else $error("Control read data wrong");

    AST_RD_STAT: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_rd_stat |=> dat_o[NUM_PER-1:0] == $past(en_w)
        && dat_o[BIT_INSLEEP] == $past(use_sleep))
        else $error("Status read data wrong");

    AST_WR_DAT_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_bus_write |=> dat_o == 32'h0000_0000)
        else $error("Read data not zero on write");

    AST_CTRL_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_ctrl_write |=> st_ff.auto_gate == $past(dat_i[BIT_AUTO_GATE]))
        else $error("Auto gate select not stored");

    AST_NO_ACK_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_bus_idle |=> !ack_o)
        else $error("Ack without request");

    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("Ack longer than one cycle");

    AST_SCG_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_scg |=> st_ff.scg0 == $past(st_ff.scg0))
        else $error("Gating register moved without write");

    AST_RATE_MATCH: assert property (@(posedge clk_i) disable iff (rst_i)
        rate_sel_o == st_ff.scg0[RATE_MSB:RATE_LSB])
        else $error("Rate output differs from field");

    AST_ACC_EXCL: assert property (@(posedge clk_i) disable iff (rst_i)
        !(acc_ok_o && acc_fault_o))
        else $error("Access both allowed and faulted");

    AST_ACC_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
        !acc_req_i |=> !acc_ok_o && !acc_fault_o)
        else $error("Access answer without request");

    AST_TICK_ALIGN: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.tick |-> st_ff.div == '0)
        else $error("Boundary tick off the divider wrap");
endmodule

/* tb/smcg_testbench.sv */
`timescale 1ns/10ps
module testbench;
    import smcg_pkg::*;
    logic              clk_i;
    logic              rst_i;
    logic              cyc_i;
    logic              stb_i;
    logic              we_i;
    logic [ADR_W-1:0]  adr_i;
    logic [3:0]        sel_i;
    logic [31:0]       dat_i;
    logic [31:0]       dat_o;
    logic              ack_o;
    logic              sleep_i;
    logic [NUM_PER-1:0] run_gate_i;
    logic              acc_req_i;
    logic [1:0]        acc_sel_i;
    logic              acc_ok_o;
    logic              acc_fault_o;
    logic [NUM_PER-1:0] periph_clk_en_o;
    logic [1:0]        rate_sel_o;
    logic [31:0]       rd;
    int                errors;
    int                n_tests;

    smcg_top #(.DIV(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .sleep_i(sleep_i), .run_gate_i(run_gate_i), .acc_req_i(acc_req_i),
        .acc_sel_i(acc_sel_i), .acc_ok_o(acc_ok_o), .acc_fault_o(acc_fault_o),
        .periph_clk_en_o(periph_clk_en_o), .rate_sel_o(rate_sel_o));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        if (k >= 20) begin
            errors++;
            wrap_up();
        end
    endtask

    task automatic settle();
        repeat (10) @(posedge clk_i);
        #1;
    endtask

    task automatic acc(input logic [1:0] n, input logic ok);
        @(posedge clk_i);
        acc_req_i <= 1'b1;
        acc_sel_i <= n;
        @(posedge clk_i);
        acc_req_i <= 1'b0;
        #1;
        chk("acc_ok", {31'h0, acc_ok_o}, {31'h0, ok});
        chk("acc_fault", {31'h0, acc_fault_o}, {31'h0, !ok});
    endtask

    task automatic t_reset();
        chk("en_rst", {28'h0, periph_clk_en_o}, 32'h0000_0004);
        chk("rate_rst", {30'h0, rate_sel_o}, 32'h0000_0000);
        wb(1'b0, 12'h110, 32'h0000_0000, rd);
        chk("scg_rst", rd, 32'h0000_0040);
    endtask

    task automatic t_mask();
        wb(1'b1, 12'h110, 32'hffff_feff, rd);
        wb(1'b0, 12'h110, 32'h0000_0000, rd);
        chk("scg_ones", rd, 32'h0011_0248);
        wb(1'b1, 12'h110, 32'h0000_0000, rd);
        wb(1'b0, 12'h110, 32'h0000_0000, rd);
        chk("scg_zero", rd, 32'h0000_0000);
        wb(1'b1, 12'h300, 32'hffff_ffff, rd);
        wb(1'b0, 12'h300, 32'h0000_0000, rd);
        chk("unmapped", rd, 32'h0000_0000);
    endtask

    task automatic t_rate();
        logic [1:0] r;
        for (int i = 0; i < 3; i++) begin
            r = 2'(2 - i);
            wb(1'b1, 12'h110, {22'h0, r, 8'h00}, rd);
            repeat (2) @(posedge clk_i);
            #1;
            chk("rate_sel", {30'h0, rate_sel_o}, {30'h0, r});
            wb(1'b0, 12'h110, 32'h0000_0000, rd);
            chk("rate_rd", rd, {22'h0, r, 8'h00});
        end
    endtask

    task automatic t_sleep();
        wb(1'b1, 12'h114, 32'h0000_0001, rd);
        wb(1'b0, 12'h110, 32'h0000_0000, rd);
        wb(1'b1, 12'h110, rd | 32'h0010_0008, rd);
        sleep_i <= 1'b1;
        settle();
        chk("en_sleep", {28'h0, periph_clk_en_o}, 32'h0000_0009);
        wb(1'b0, 12'h118, 32'h0000_0000, rd);
        chk("stat_rd", rd, 32'h0000_0109);
        wb(1'b0, 12'h114, 32'h0000_0000, rd);
        chk("ctrl_rd", rd, 32'h0000_0001);
        for (int n = 0; n < 4; n++) begin
            acc(2'(n), (n == 0) || (n == 3));
        end
        sleep_i <= 1'b0;
        run_gate_i <= 4'h6;
        settle();
        chk("en_run", {28'h0, periph_clk_en_o}, 32'h0000_0006);
        acc(2'h0, 1'b0);
        wb(1'b1, 12'h114, 32'h0000_0000, rd);
        sleep_i <= 1'b1;
        settle();
        chk("en_noacg", {28'h0, periph_clk_en_o}, 32'h0000_0006);
        acc(2'h1, 1'b1);
    endtask

    task automatic wrap_up();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        wrap_up();
    end

    initial begin
        errors = 0;
        n_tests = 0;
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 12'h000;
        sel_i = 4'h0;
        dat_i = 32'h0000_0000;
        sleep_i = 1'b0;
        run_gate_i = 4'h4;
        acc_req_i = 1'b0;
        acc_sel_i = 2'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        t_reset();
        t_mask();
        t_rate();
        t_sleep();
        wrap_up();
    end
endmodule
